/* File: pattern_test_pkg.sv */
// constants shared by the lane pattern test logic
// assumes a 40-bit raw media-attach lane and a 40 MHz system clock
package pattern_test_pkg;

    // lane word width and fixed patterns
    localparam int          DATA_W       = 40;
    localparam int          PRBS_W       = 7;
    localparam logic [39:0] COMMA_WORD   = 40'h3EB053EB05;
    localparam logic [6:0]  PRBS_SEED    = 7'h7F;
    localparam logic [39:0] COUNT_START  = 40'h0000000000;

    // register offsets (byte addresses)
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_ERR_CNT  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h14;

    // control fields
    localparam int          CTRL_RELEASE = 0;
    localparam int          CTRL_MODE    = 1;

    // status fields
    localparam int          STS_DONE     = 0;
    localparam int          STS_TX_OK    = 1;
    localparam int          STS_RX_OK    = 2;
    localparam int          STS_IDLE     = 3;
    localparam int          STS_SEEDED   = 4;

    // interrupt event fields
    localparam int          EV_W         = 3;
    localparam int          EV_MISMATCH  = 0;
    localparam int          EV_ALIGNED   = 1;
    localparam int          EV_IDLE      = 2;

    // alignment state machine
    typedef enum logic [1:0] {
        ALIGN_HUNT    = 2'b00,
        ALIGN_SLIP_HI = 2'b01,
        ALIGN_SLIP_LO = 2'b10,
        ALIGN_DONE    = 2'b11
    } align_t;

endpackage

/* File: sync_2ff.sv */
// two-stage synchroniser for a bundle of asynchronous inputs
// assumes every bit is sampled only by the second stage
module sync_2ff
    #(parameter int WIDTH = 1)
(
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    // bundle
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_t;

    sync_t st_reg;
    sync_t st_next;

    initial begin
        if (WIDTH < 1) $error("sync_2ff: WIDTH must be at least 1");
    end

    always_comb begin
        st_next.meta = i_async;
        st_next.held = st_reg.meta;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.held;

endmodule

/* File: pma_pattern_test_align.sv */
// pattern generator, prbs checker, bit-slip aligner and counter checker
// assumes lane clocks are far slower than i_sys_clk and sampled by it
// Operation
// - prbs mode sends a fresh 40-bit prbs7 word on each transmit clock.
// - prbs checker seeds from received words and predicts the next word.
// - a received prbs word differing from prediction raises the error flag.
// - checking waits until the lane reports valid receive data.
// - lane words are 40 bits; the lane runs raw at 200 Mbps.
// - bit-slip mode sends the comma pattern until alignment is done.
// - the aligner compares each word received in the hunt state with the comma pattern.
// - the aligner keeps requesting slips until a comma word arrives.
// - a received comma sets alignment-done, starting generator and checker.
// - after alignment the generator sends a counter rising by one per word.
// - the counter checker flags any word differing from its expected value.
// - each slip request moves the lane word boundary by one bit.
// - slips trigger on rising edges; the request returns low between slips.
// - transmit logic follows the transmit clock, receive logic the receive.
// - the lane's transmit-stable and receive-ready flags gate the test logic.
// - the lane's electrical-idle flag is observed and reported.
module pma_pattern_test_align
    import pattern_test_pkg::*;
    #(parameter int SLIP_SETTLE = 2,
      parameter int ERR_CNT_W   = 16)
(
    // system clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    // lane clocks and flags
    input  wire logic              i_tx_regional_clock,
    input  wire logic              i_rx_regional_clock,
    input  wire logic              i_tx_path_stable,
    input  wire logic              i_rx_path_ready,
    input  wire logic              i_rx_word_valid,
    input  wire logic              i_rx_electrical_idle,
    // lane data
    input  wire logic [DATA_W-1:0] i_rx_data,
    output logic      [DATA_W-1:0] o_tx_data,
    output logic                   o_lane_bit_slip_request,
    output logic                   o_coding_layer_reset_n,
    output logic                   o_media_attach_reset_n,
    // register port
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_write,
    input  wire logic              i_reg_read,
    output logic      [31:0]       o_reg_rdata,
    // status
    output logic                   o_irq,
    output logic                   o_align_done,
    output logic                   o_pattern_error
);

    localparam int SET_W = $clog2(SLIP_SETTLE + 1);
    localparam int SYNC_W = DATA_W + 6;

    initial begin
        if (SLIP_SETTLE < 1) $error("SLIP_SETTLE must be at least 1");
        if (ERR_CNT_W < 1 || ERR_CNT_W > 32) $error("ERR_CNT_W 1..32");
    end

    typedef struct packed {
        logic                tx_clk_q;
        logic                rx_clk_q;
        logic                idle_q;
        logic [DATA_W-1:0]   tx_data;
        logic [PRBS_W-1:0]   gen_prbs;
        logic [DATA_W-1:0]   gen_count;
        logic [PRBS_W-1:0]   chk_prbs;
        logic                chk_seeded;
        logic [DATA_W-1:0]   chk_expect;
        logic                pattern_error;
        align_t              align;
        logic [SET_W-1:0]    settle;
        logic                slip;
        logic                align_done;
        logic                lane_release;
        logic                mode_slip;
        logic [ERR_CNT_W-1:0] err_count;
        logic [EV_W-1:0]     irq_stat;
        logic [EV_W-1:0]     irq_en;
        logic                irq;
        logic [31:0]         rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // one prbs7 (x^7 + x^6 + 1) word: {next state, word}, bit 0 sent first
    function automatic logic [PRBS_W+DATA_W-1:0] prbs_step(
        input logic [PRBS_W-1:0] seed);
        logic [PRBS_W-1:0] s;
        logic [DATA_W-1:0] w;
        s = seed;
        w = '0;
        for (int i = 0; i < DATA_W; i++) begin
            w[i] = s[6] ^ s[5];
            s    = {s[5:0], w[i]};
        end
        return {s, w};
    endfunction

    // state that the last seven bits of a word leave behind
    function automatic logic [PRBS_W-1:0] prbs_seed_of(
        input logic [DATA_W-1:0] w);
        logic [PRBS_W-1:0] s;
        s = '0;
        for (int i = 0; i < PRBS_W; i++) begin
            s[i] = w[DATA_W-1-i];
        end
        return s;
    endfunction

    // every lane signal crosses through the same two stages
    logic [SYNC_W-1:0] sync_out;
    logic [DATA_W-1:0] rx_data_s;
    logic              tx_clk_s;
    logic              rx_clk_s;
    logic              tx_stable_s;
    logic              rx_ready_s;
    logic              rx_valid_s;
    logic              idle_s;

    sync_2ff #(.WIDTH(SYNC_W)) lane_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   ({i_rx_data, i_tx_regional_clock, i_rx_regional_clock,
                     i_tx_path_stable, i_rx_path_ready, i_rx_word_valid,
                     i_rx_electrical_idle}),
        .o_sync    (sync_out)
    );

    assign {rx_data_s, tx_clk_s, rx_clk_s, tx_stable_s,
            rx_ready_s, rx_valid_s, idle_s} = sync_out;

    logic                     tx_edge;
    logic                     rx_sample;
    logic                     rx_take;
    logic                     prbs_mismatch;
    logic                     cnt_mismatch;
    logic [EV_W-1:0]          events;
    logic [PRBS_W+DATA_W-1:0] tx_step;
    logic [PRBS_W+DATA_W-1:0] rx_pred;

    // transmit words launch on the lane clock's rising edge; receive words
    // are taken on its falling edge, mid-word, where the data is settled
    assign tx_edge   = tx_clk_s & ~st_reg.tx_clk_q;
    assign rx_sample = ~rx_clk_s & st_reg.rx_clk_q;
    assign rx_take   = rx_sample & rx_ready_s & rx_valid_s & ~idle_s;
    assign tx_step   = prbs_step(st_reg.gen_prbs);
    assign rx_pred   = prbs_step(st_reg.chk_prbs);
    // words still in flight while the lane is parked are never judged
    assign prbs_mismatch = rx_take & st_reg.lane_release & ~st_reg.mode_slip
                         & st_reg.chk_seeded
                         & (rx_data_s != rx_pred[DATA_W-1:0]);
    assign cnt_mismatch  = rx_take & st_reg.lane_release & st_reg.mode_slip
                         & (st_reg.align == ALIGN_DONE) & st_reg.chk_seeded
                         & (rx_data_s != st_reg.chk_expect);

    always_comb begin
        st_next = st_reg;
        st_next.tx_clk_q      = tx_clk_s;
        st_next.rx_clk_q      = rx_clk_s;
        st_next.idle_q        = idle_s;
        st_next.pattern_error = 1'b0;
        st_next.rdata         = '0;
        events                = '0;

        if (!st_reg.lane_release) begin
            // lane held in reset: datapath parked
            st_next.tx_data    = '0;
            st_next.gen_prbs   = PRBS_SEED;
            st_next.gen_count  = COUNT_START;
            st_next.chk_seeded = 1'b0;
            st_next.align      = ALIGN_HUNT;
            st_next.settle     = '0;
            st_next.slip       = 1'b0;
            st_next.align_done = 1'b0;
        end else begin
            if (tx_edge && tx_stable_s) begin
                if (!st_reg.mode_slip) begin
                    {st_next.gen_prbs, st_next.tx_data} = tx_step;
                end else if (!st_reg.align_done) begin
                    st_next.tx_data = COMMA_WORD;
                end else begin
                    st_next.tx_data   = st_reg.gen_count;
                    st_next.gen_count = st_reg.gen_count + 40'h0000000001;
                end
            end
            if (rx_take && !st_reg.mode_slip) begin
                // reseeding from every word keeps a single bit error local
                st_next.chk_prbs   = prbs_seed_of(rx_data_s);
                st_next.chk_seeded = 1'b1;
            end
            if (rx_sample && st_reg.mode_slip) begin
                unique case (st_reg.align)
                    ALIGN_HUNT: begin
                        if (rx_take && rx_data_s == COMMA_WORD) begin
                            st_next.align      = ALIGN_DONE;
                            st_next.align_done = 1'b1;
                            events[EV_ALIGNED] = 1'b1;
                        end else if (rx_take) begin
                            st_next.slip  = 1'b1;
                            st_next.align = ALIGN_SLIP_HI;
                        end
                    end
                    ALIGN_SLIP_HI: begin
                        st_next.slip   = 1'b0;
                        st_next.settle = SET_W'(SLIP_SETTLE - 1);
                        st_next.align  = ALIGN_SLIP_LO;
                    end
                    ALIGN_SLIP_LO: begin
                        // let the shifted boundary reach the fabric first
                        if (st_reg.settle == '0) begin
                            st_next.align = ALIGN_HUNT;
                        end else begin
                            st_next.settle = st_reg.settle - 1'b1;
                        end
                    end
                    ALIGN_DONE: begin
                        // commas still in flight are skipped before seeding
                        if (rx_take && !st_reg.chk_seeded
                                && rx_data_s != COMMA_WORD) begin
                            st_next.chk_seeded = 1'b1;
                            st_next.chk_expect = rx_data_s + 40'h0000000001;
                        end else if (rx_take && st_reg.chk_seeded) begin
                            st_next.chk_expect = st_reg.chk_expect
                                               + 40'h0000000001;
                        end
                    end
                endcase
            end
        end

        if (prbs_mismatch || cnt_mismatch) begin
            st_next.pattern_error = 1'b1;
            events[EV_MISMATCH]   = 1'b1;
            if (st_reg.err_count != '1) begin
                st_next.err_count = st_reg.err_count + 1'b1;
            end
        end
        events[EV_IDLE] = idle_s & ~st_reg.idle_q;

        // register writes
        if (i_reg_write) begin
            unique case (i_reg_addr)
                OFS_CTRL: begin
                    st_next.lane_release = i_reg_wdata[CTRL_RELEASE];
                    st_next.mode_slip    = i_reg_wdata[CTRL_MODE];
                end
                OFS_ERR_CNT: st_next.err_count = '0;
                OFS_IRQ_EN:  st_next.irq_en    = i_reg_wdata[EV_W-1:0];
                default: ;
            endcase
        end
        // a new event outranks a clear in the same cycle
        if (i_reg_write && i_reg_addr == OFS_IRQ_CLR) begin
            st_next.irq_stat = (st_reg.irq_stat & ~i_reg_wdata[EV_W-1:0])
                             | events;
        end else begin
            st_next.irq_stat = st_reg.irq_stat | events;
        end
        st_next.irq = |(st_next.irq_stat & st_next.irq_en);

        // register reads, answered next cycle
        if (i_reg_read) begin
            unique case (i_reg_addr)
                OFS_CTRL: begin
                    st_next.rdata[CTRL_RELEASE] = st_reg.lane_release;
                    st_next.rdata[CTRL_MODE]    = st_reg.mode_slip;
                end
                OFS_STATUS: begin
                    st_next.rdata[STS_DONE]   = st_reg.align_done;
                    st_next.rdata[STS_TX_OK]  = tx_stable_s;
                    st_next.rdata[STS_RX_OK]  = rx_ready_s;
                    st_next.rdata[STS_IDLE]   = idle_s;
                    st_next.rdata[STS_SEEDED] = st_reg.chk_seeded;
                end
                OFS_ERR_CNT:  st_next.rdata[ERR_CNT_W-1:0] = st_reg.err_count;
                OFS_IRQ_STAT: st_next.rdata[EV_W-1:0] = st_reg.irq_stat;
                OFS_IRQ_EN:   st_next.rdata[EV_W-1:0] = st_reg.irq_en;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tx_data               = st_reg.tx_data;
    assign o_lane_bit_slip_request = st_reg.slip;
    assign o_coding_layer_reset_n  = st_reg.lane_release;
    assign o_media_attach_reset_n  = st_reg.lane_release;
    assign o_reg_rdata             = st_reg.rdata;
    assign o_irq                   = st_reg.irq;
    assign o_align_done            = st_reg.align_done;
    assign o_pattern_error         = st_reg.pattern_error;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_slip_low_gap: assert property (
        $fell(o_lane_bit_slip_request) |=> !o_lane_bit_slip_request [*3])
        else $error("slip request not held low between slips");
    a_comma_sets_done: assert property (
        (st_reg.mode_slip && st_reg.lane_release && rx_sample && rx_take
         && st_reg.align == ALIGN_HUNT && rx_data_s == COMMA_WORD)
        |=> o_align_done && !o_lane_bit_slip_request)
        else $error("comma received but alignment not done");
    a_miss_slips: assert property (
        (st_reg.mode_slip && st_reg.lane_release && rx_sample && rx_take
         && st_reg.align == ALIGN_HUNT && rx_data_s != COMMA_WORD)
        |=> $rose(o_lane_bit_slip_request) && !o_align_done)
        else $error("mismatch without slip request");
    a_done_sticks: assert property (
        (o_align_done && st_reg.lane_release) |=> o_align_done)
        else $error("alignment done dropped");
    a_tx_comma_sent: assert property (
        (st_reg.mode_slip && st_reg.lane_release && !o_align_done
         && tx_edge && tx_stable_s) |=> o_tx_data == COMMA_WORD)
        else $error("comma not sent before alignment");
    a_tx_count_next: assert property (
        (st_reg.mode_slip && st_reg.lane_release && o_align_done
         && tx_edge && tx_stable_s)
        |=> o_tx_data == $past(st_reg.gen_count)
            && st_reg.gen_count == o_tx_data + 40'h0000000001)
        else $error("counter word not incremented");
    a_prbs_err_flag: assert property (
        prbs_mismatch |=> o_pattern_error ##1 !o_pattern_error)
        else $error("prbs mismatch not flagged");
    a_check_waits: assert property (
        (st_reg.lane_release && rx_sample && !rx_valid_s)
        |=> $stable(st_reg.chk_seeded) && !o_pattern_error)
        else $error("checker acted on invalid receive data");

endmodule

/* File: lane_model.sv */
// behavioural lane: free-running lane clocks, loopback and bit-slip
// assumes the test logic drives both lane resets and the slip request
module lane_model
    import pattern_test_pkg::*;
(
    // from the test logic
    input  wire logic [DATA_W-1:0] i_tx_data,
    input  wire logic              i_slip,
    input  wire logic              i_pcs_rst_n,
    input  wire logic              i_pma_rst_n,
    // bench controls
    input  wire logic              i_valid,
    input  wire logic              i_idle,
    input  wire logic [DATA_W-1:0] i_flip,
    // to the test logic
    output logic                   o_tx_clk,
    output logic                   o_rx_clk,
    output logic                   o_stable,
    output logic                   o_ready,
    output logic                   o_valid,
    output logic                   o_idle,
    output logic      [DATA_W-1:0] o_rx_data,
    output logic      [7:0]        o_slips
);
    timeunit 1ns;
    timeprecision 1ps;
    // start off the comma boundary so the aligner must hunt
    localparam int START_OFS = 33;
    logic                up;
    logic [2*DATA_W-1:0] both_w;
    logic [DATA_W-1:0]   prev_w = '0;
    logic [DATA_W-1:0]   cur_w  = '0;
    int                  ofs    = START_OFS;

    assign up       = (i_pcs_rst_n === 1'b1) && (i_pma_rst_n === 1'b1);
    assign both_w   = {cur_w, prev_w};
    assign o_stable = up;
    assign o_ready  = up;
    assign o_valid  = up && (i_valid === 1'b1);
    assign o_idle   = i_idle;

    initial begin
        o_tx_clk = 1'b0;
        o_slips  = 8'h00;
        forever #100 o_tx_clk = ~o_tx_clk;
    end
    // receive clock keeps a phase unrelated to the transmit clock
    initial begin
        o_rx_clk  = 1'b0;
        o_rx_data = '0;
        #37;
        forever #100 o_rx_clk = ~o_rx_clk;
    end

    always @(negedge o_tx_clk) begin
        prev_w <= up ? cur_w : '0;
        cur_w  <= up ? i_tx_data : '0;
    end
    // only the rising edge slips; a held request does nothing more
    always @(posedge i_slip or negedge up) begin
        if (!up) begin
            ofs     <= START_OFS;
            o_slips <= 8'h00;
        end else begin
            ofs     <= (ofs + 1) % DATA_W;
            o_slips <= o_slips + 8'h01;
        end
    end
    // a lane in reset shows a toggling word: the last good one and its inverse in turn
    always @(posedge o_rx_clk) begin
        if (up) begin
            o_rx_data <= both_w[ofs +: DATA_W] ^ i_flip;
        end else begin
            o_rx_data <= ~o_rx_data;
        end
    end
endmodule

/* File: pma_pattern_test_align_tb.sv */
// bench for the lane pattern test logic
// assumes the lane model loops transmit words back with bit-slip
module pma_pattern_test_align_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pattern_test_pkg::*;
    logic              sys_clk, rst, wr, rd, slip, pcs_n, pma_n;
    logic              tx_clk, rx_clk, stable, ready, valid, idle;
    logic              valid_en, idle_en, irq, done, perr;
    logic [7:0]        addr, slips;
    logic [31:0]       wdata, rdata;
    logic [DATA_W-1:0] tx_data, rx_data, flip;
    int                err_total, total_checks, cycles, n_perr;

    pma_pattern_test_align DUT (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_tx_regional_clock(tx_clk), .i_rx_regional_clock(rx_clk),
        .i_tx_path_stable(stable), .i_rx_path_ready(ready),
        .i_rx_word_valid(valid), .i_rx_electrical_idle(idle),
        .i_rx_data(rx_data), .o_tx_data(tx_data),
        .o_lane_bit_slip_request(slip), .o_coding_layer_reset_n(pcs_n),
        .o_media_attach_reset_n(pma_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
        .o_reg_rdata(rdata), .o_irq(irq), .o_align_done(done),
        .o_pattern_error(perr));
    lane_model lane (.i_tx_data(tx_data), .i_slip(slip),
        .i_pcs_rst_n(pcs_n), .i_pma_rst_n(pma_n), .i_valid(valid_en),
        .i_idle(idle_en), .i_flip(flip), .o_tx_clk(tx_clk),
        .o_rx_clk(rx_clk), .o_stable(stable), .o_ready(ready),
        .o_valid(valid), .o_idle(idle), .o_rx_data(rx_data),
        .o_slips(slips));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // error pulses last one cycle, so they are counted on every edge
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (perr === 1'b1) n_perr <= n_perr + 1;
        if (cycles == 40000) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [39:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        check(40'(rdata), 40'(e), "read data");
    endtask
    task automatic wait_words(input int n);
        repeat (n) @(posedge rx_clk);
        @(posedge sys_clk);
    endtask
    task automatic get_tx(output logic [DATA_W-1:0] w);
        @(negedge tx_clk);
        w = tx_data;
    endtask
    // one received word carries the mask, the ones around it do not
    task automatic flip_word(input logic [DATA_W-1:0] m);
        @(posedge rx_clk);
        @(posedge sys_clk);
        flip <= m;
        @(posedge rx_clk);
        @(posedge sys_clk);
        flip <= '0;
    endtask
    function automatic logic prbs_ok(input logic [DATA_W-1:0] p, c);
        logic [2*DATA_W-1:0] s;
        s = {c, p};
        prbs_ok = (c != '0);
        for (int n = DATA_W; n < 2*DATA_W; n++) begin
            if (s[n] !== (s[n-7] ^ s[n-6])) prbs_ok = 1'b0;
        end
    endfunction

    task automatic t_reset();
        check(40'({pcs_n, pma_n}), '0, "lane resets");
        check(tx_data, '0, "tx at reset");
        reg_rd(OFS_CTRL, 32'h0);
        reg_rd(OFS_STATUS, 32'h0);
        reg_rd(OFS_IRQ_EN, 32'h0);
        reg_wr(8'h20, 32'hFF);
        reg_rd(8'h20, 32'h0);
    endtask
    task automatic t_prbs();
        logic [DATA_W-1:0] a, b;
        int n0;
        valid_en <= 1'b0;
        reg_wr(OFS_CTRL, 32'h1);
        reg_rd(OFS_CTRL, 32'h1);
        check(40'({pcs_n, pma_n}), 40'h3, "lane released");
        wait_words(6);
        reg_rd(OFS_STATUS, 32'h06);
        valid_en <= 1'b1;
        wait_words(6);
        reg_rd(OFS_STATUS, 32'h16);
        check(40'(n_perr), '0, "clean prbs");
        get_tx(a);
        repeat (8) begin
            get_tx(b);
            check(40'(prbs_ok(a, b)), 40'h1, "prbs7 tx");
            a = b;
        end
        n0 = n_perr;
        flip_word(40'h1);
        wait_words(3);
        check(40'(n_perr - n0), 40'h1, "prbs error");
        reg_rd(OFS_ERR_CNT, 32'h1);
        reg_rd(OFS_IRQ_STAT, 32'h1);
        check(40'(irq), '0, "masked irq");
        reg_wr(OFS_ERR_CNT, 32'h0);
        reg_rd(OFS_ERR_CNT, 32'h0);
        reg_wr(OFS_IRQ_CLR, 32'h7);
        reg_rd(OFS_IRQ_STAT, 32'h0);
    endtask
    task automatic t_align();
        logic [DATA_W-1:0] a, b;
        int n0, i;
        valid_en <= 1'b0;
        reg_wr(OFS_CTRL, 32'h0);
        reg_wr(OFS_CTRL, 32'h2);
        reg_wr(OFS_IRQ_EN, 32'h2);
        reg_wr(OFS_CTRL, 32'h3);
        n0 = n_perr;
        wait_words(4);
        get_tx(a);
        check(a, COMMA_WORD, "comma tx");
        valid_en <= 1'b1;
        i = 0;
        while (done !== 1'b1 && i < 3000) begin
            @(posedge sys_clk);
            i++;
        end
        check(40'(done), 40'h1, "aligned");
        check(40'(slips), 40'h7, "slip count");
        repeat (2) @(posedge sys_clk);
        #1;
        check(40'(irq), 40'h1, "aligned irq");
        get_tx(a);
        repeat (6) begin
            get_tx(b);
            check(b, a + 40'h1, "counter tx");
            a = b;
        end
        wait_words(3);
        check(40'(n_perr - n0), '0, "clean counter");
        check(40'({slip, slips}), 40'h7, "slips stop");
        flip_word(40'h10);
        wait_words(3);
        check(40'(n_perr - n0), 40'h1, "counter error");
        reg_rd(OFS_ERR_CNT, 32'h1);
        reg_wr(OFS_IRQ_CLR, 32'h2);
        repeat (2) @(posedge sys_clk);
        #1;
        check(40'(irq), '0, "irq cleared");
    endtask
    task automatic t_idle();
        reg_wr(OFS_CTRL, 32'h0);
        reg_wr(OFS_IRQ_CLR, 32'h7);
        reg_wr(OFS_IRQ_EN, 32'h4);
        idle_en <= 1'b1;
        repeat (6) @(posedge sys_clk);
        reg_rd(OFS_STATUS, 32'h08);
        reg_rd(OFS_IRQ_STAT, 32'h4);
        check(40'(irq), 40'h1, "idle irq");
        idle_en <= 1'b0;
        reg_wr(OFS_IRQ_CLR, 32'h4);
        reg_wr(OFS_STATUS, 32'hFF);
        reg_rd(OFS_STATUS, 32'h0);
        check(40'(irq), '0, "idle irq cleared");
    endtask

    initial begin
        rst          = 1'b1;
        addr         = '0;
        wdata        = '0;
        wr           = 1'b0;
        rd           = 1'b0;
        valid_en     = 1'b0;
        idle_en      = 1'b0;
        flip         = '0;
        err_total    = 0;
        total_checks = 0;
        cycles       = 0;
        n_perr       = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_prbs();
        t_align();
        t_idle();
        give_verdict();
    end
endmodule
